// ===== verilog/qpdbs_top.sv
/*
  Two-port double-data-rate static memory with a fixed burst of two.
  Pins from the controller, including the input clock pair, are sampled
  by the system clock through two flip-flops; their rising edges are
  found from the sampled levels. Assumes the system clock runs several
  times faster than the input clock pair.
*/
// Contract
// R1: Read address, selects, first write beat on true edge
// R2: Write address, enables, second beat on complement edge
// R3: Per-lane enables gate each beat's bytes
// R4: First write beat buffered before write address arrives
// R5: Controller presents write beats on consecutive edges
// R6: First read beat after two cycles latency
// R7: Second read beat follows on true edge
// R8: Every access moves exactly two beats
// R9: Separate input and output data, concurrent operations
// R10: Echo clock pair aligned with read data
// R11: Operations start on true edge, self-timed internally
// R12: Read beats launched from input clock pair edges
// R13: Organisation set by address and data width
// R14: Valid flag high while read data stand
// R15: Loop bypass gives one-cycle read latency
// R16: Echo clocks toggle continuously
// R17: Address ignored when nothing is selected
// R18: Reads see pending write data, merged per lane
// R19: Selects active low at true edge
`timescale 1ns/1ns
`include "qpdbs_defines.svh"

module qpdbs_top #(
  parameter int ADDR_W = `QPDBS_ADDR_W, // R13
  parameter int DATA_W = `QPDBS_DATA_W, // R13
  parameter int LANES  = `QPDBS_DATA_W / `QPDBS_LANE_W
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              link_clock_true,
  input  wire logic              link_clock_complement,
  input  wire logic              read_select_n,
  input  wire logic              write_select_n,
  input  wire logic              dll_bypass_n,
  input  wire logic [ADDR_W-1:0] shared_address,
  input  wire logic [LANES-1:0]  byte_write_enable_n,
  input  wire logic [DATA_W-1:0] write_data_in,
  output logic      [DATA_W-1:0] read_data_out,
  output logic                   read_data_oe,
  output logic                   read_data_valid,
  output logic                   echo_clock_true,
  output logic                   echo_clock_complement
);
  localparam int WORD_W = `QPDBS_BEATS * DATA_W;
  localparam int MASK_W = `QPDBS_BEATS * LANES;
  localparam int LW     = DATA_W / LANES;
  localparam int SW     = 5 + ADDR_W + LANES + DATA_W;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [SW-1:0]     meta_r;
  logic [SW-1:0]     sync_r;
  logic              k_s;
  logic              kn_s;
  logic              rsel_n_s;
  logic              wsel_n_s;
  logic              dll_s;
  logic [ADDR_W-1:0] addr_s;
  logic [LANES-1:0]  bw_n_s;
  logic [DATA_W-1:0] data_s;

  // Reset to the pins' idle levels: selects and lane enables high
  localparam logic [SW-1:0] SYNC_IDLE = {2'h0, 2'h3, 1'h1, {ADDR_W{1'h0}}, {LANES{1'h1}},
                                         {DATA_W{1'h0}}};

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= SYNC_IDLE;
      sync_r <= SYNC_IDLE;
    end else begin
      meta_r <= {link_clock_true, link_clock_complement, read_select_n, write_select_n,
                 dll_bypass_n, shared_address, byte_write_enable_n, write_data_in};
      sync_r <= meta_r;
    end
  end

  assign {k_s, kn_s, rsel_n_s, wsel_n_s, dll_s, addr_s, bw_n_s, data_s} = sync_r;

  // ----------------------------------------------------------------
  // Input clock edge detection
  // ----------------------------------------------------------------
  logic [`QPDBS_HIST_W-1:0] k_hist_r;
  logic [`QPDBS_HIST_W-1:0] kn_hist_r;
  logic                     k_rise;
  logic                     kn_rise;
  logic                     k_rise_d2;
  logic                     kn_rise_d2;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      k_hist_r  <= '0;
      kn_hist_r <= '0;
    end else begin
      k_hist_r  <= {k_hist_r[`QPDBS_HIST_W-2:0], k_s};
      kn_hist_r <= {kn_hist_r[`QPDBS_HIST_W-2:0], kn_s};
    end
  end

  assign k_rise     = k_s & ~k_hist_r[0];
  assign kn_rise    = kn_s & ~kn_hist_r[0];
  assign k_rise_d2  = k_hist_r[1] & ~k_hist_r[2];
  assign kn_rise_d2 = kn_hist_r[1] & ~kn_hist_r[2];

  // ----------------------------------------------------------------
  // Latency mode
  // ----------------------------------------------------------------
  qpdbs_pkg::qpdbs_lat_t lat_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lat_r <= qpdbs_pkg::QPDBS_LAT_TWO;
    end else if (k_rise) begin
      lat_r <= dll_s ? qpdbs_pkg::QPDBS_LAT_TWO : qpdbs_pkg::QPDBS_LAT_ONE; // R15
    end
  end

  // ----------------------------------------------------------------
  // True edge capture
  // ----------------------------------------------------------------
  logic              rd_req_r;
  logic [ADDR_W-1:0] rd_addr_r;
  logic              wr_pend_r;
  logic [DATA_W-1:0] wbeat1_r;
  logic [LANES-1:0]  wbw1_n_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_req_r  <= 1'b0;
      rd_addr_r <= '0;
    end else if (k_rise) begin // R11
      rd_req_r <= ~rsel_n_s; // R19
      if (!rsel_n_s) begin
        rd_addr_r <= addr_s; // R1 R17
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      wbeat1_r  <= '0;
      wbw1_n_r  <= '1;
    end else if (k_rise) begin // R11
      wr_pend_r <= ~wsel_n_s; // R19
      wbeat1_r  <= data_s; // R1 R4
      wbw1_n_r  <= bw_n_s; // R3
    end
  end

  // ----------------------------------------------------------------
  // Array access on complement edge
  // ----------------------------------------------------------------
  qpdbs_mem_if #(.ADDR_W(ADDR_W), .WORD_W(WORD_W), .MASK_W(MASK_W)) mem_bus ();

  assign mem_bus.we    = kn_rise & wr_pend_r; // R2 R11
  assign mem_bus.waddr = addr_s; // R2
  assign mem_bus.wmask = {~bw_n_s, ~wbw1_n_r}; // R3
  assign mem_bus.wdata = {data_s, wbeat1_r}; // R2 R8
  assign mem_bus.raddr = rd_addr_r;

  qpdbs_mem #(.ADDR_W(ADDR_W), .WORD_W(WORD_W), .MASK_W(MASK_W)) u_mem (
    .clock (clock),
    .port  (mem_bus.array)
  );

  // ----------------------------------------------------------------
  // Write forwarding
  // ----------------------------------------------------------------
  logic              lookup_r;
  logic              look_valid_r;
  logic              fwd_r;
  logic [MASK_W-1:0] fwd_mask_r;
  logic [WORD_W-1:0] fwd_data_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lookup_r <= 1'b0;
    end else begin
      lookup_r <= kn_rise; // R11
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      look_valid_r <= 1'b0;
      fwd_r        <= 1'b0;
      fwd_mask_r   <= '0;
      fwd_data_r   <= '0;
    end else if (kn_rise) begin
      look_valid_r <= rd_req_r;
      fwd_r        <= wr_pend_r & rd_req_r & (addr_s == rd_addr_r); // R18
      fwd_mask_r   <= mem_bus.wmask;
      fwd_data_r   <= mem_bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read pipeline
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] merged;
  logic              stage0_v_r;
  logic [WORD_W-1:0] stage0_r;
  logic              stage1_v_r;
  logic [WORD_W-1:0] stage1_r;

  for (genvar g = 0; g < MASK_W; g++) begin : g_merge
    assign merged[g*LW +: LW] = (fwd_r && fwd_mask_r[g]) ? fwd_data_r[g*LW +: LW]
                                                         : mem_bus.rdata[g*LW +: LW]; // R18
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage0_v_r <= 1'b0;
      stage0_r   <= '0;
    end else if (lookup_r) begin
      stage0_v_r <= look_valid_r;
      stage0_r   <= merged;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_v_r <= 1'b0;
      stage1_r   <= '0;
    end else if (lookup_r) begin
      stage1_v_r <= stage0_v_r; // R6
      stage1_r   <= stage0_r;
    end
  end

  // ----------------------------------------------------------------
  // Output launch
  // ----------------------------------------------------------------
  logic              src_v;
  logic [WORD_W-1:0] src;
  logic              pend_r;
  logic [DATA_W-1:0] second_r;

  assign src_v = (lat_r == qpdbs_pkg::QPDBS_LAT_ONE) ? stage0_v_r : stage1_v_r; // R15 R6
  assign src   = (lat_r == qpdbs_pkg::QPDBS_LAT_ONE) ? stage0_r : stage1_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      read_data_out <= '0;
      second_r      <= '0;
    end else if (kn_rise_d2) begin // R12
      if (src_v) begin
        read_data_out <= src[DATA_W-1:0]; // R6 R9
      end
      second_r <= src[WORD_W-1:DATA_W];
    end else if (k_rise_d2 && pend_r) begin // R12
      read_data_out <= second_r; // R7 R8
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pend_r <= 1'b0;
    end else if (kn_rise_d2) begin
      pend_r <= src_v;
    end else if (k_rise_d2) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      read_data_valid <= 1'b0;
      read_data_oe    <= 1'b0;
    end else if (kn_rise_d2) begin
      read_data_valid <= src_v; // R14
      read_data_oe    <= src_v;
    end else if (k_rise_d2) begin
      read_data_valid <= pend_r; // R14
      read_data_oe    <= pend_r;
    end
  end

  // ----------------------------------------------------------------
  // Echo clocks
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      echo_clock_true <= 1'b0;
    end else begin
      echo_clock_true <= k_hist_r[1]; // R10 R16
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      echo_clock_complement <= 1'b0;
    end else begin
      echo_clock_complement <= kn_hist_r[1]; // R10 R16
    end
  end

endmodule

// ===== verilog/qpdbs_defines.svh
/*
  Constants of the two-port burst-of-two memory: default organisation,
  lane width, beat count and edge history depth.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef QPDBS_DEFINES_SVH
`define QPDBS_DEFINES_SVH

// ----------------------------------------------------------------
// Organisation
// ----------------------------------------------------------------
`define QPDBS_ADDR_W   19
`define QPDBS_DATA_W   36
`define QPDBS_LANE_W   9
`define QPDBS_BEATS    2

// ----------------------------------------------------------------
// Pin sampling
// ----------------------------------------------------------------
`define QPDBS_HIST_W   3

`endif

// ===== verilog/qpdbs_pkg.sv
/*
  Types shared by the memory block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package qpdbs_pkg;

  // ----------------------------------------------------------------
  // Read latency mode
  // ----------------------------------------------------------------
  typedef enum logic {
    QPDBS_LAT_ONE,
    QPDBS_LAT_TWO
  } qpdbs_lat_t;

endpackage

// ===== verilog/qpdbs_mem_if.sv
/*
  Interface between the pin logic and the storage array.
  Assumes one clock shared by both ends; the array reads through a register.
*/
`timescale 1ns/1ns
`include "qpdbs_defines.svh"

interface qpdbs_mem_if #(
  parameter int ADDR_W = `QPDBS_ADDR_W,
  parameter int WORD_W = `QPDBS_BEATS * `QPDBS_DATA_W,
  parameter int MASK_W = `QPDBS_BEATS * `QPDBS_DATA_W / `QPDBS_LANE_W
);
  logic              we;
  logic [ADDR_W-1:0] waddr;
  logic [MASK_W-1:0] wmask;
  logic [WORD_W-1:0] wdata;
  logic [ADDR_W-1:0] raddr;
  logic [WORD_W-1:0] rdata;

  modport ctrl (output we, output waddr, output wmask, output wdata, output raddr,
                input rdata);
  modport array (input we, input waddr, input wmask, input wdata, input raddr,
                 output rdata);
endinterface

// ===== verilog/qpdbs_mem.sv
/*
  Storage array: one write port with per-lane enables, one read port
  whose data come out of a register one clock after the address.
  Assumes the controller side of qpdbs_mem_if on the same clock.
*/
`timescale 1ns/1ns

module qpdbs_mem #(
  parameter int ADDR_W = 19,
  parameter int WORD_W = 72,
  parameter int MASK_W = 8
) (
  input wire logic      clock,
  qpdbs_mem_if.array    port
);
  localparam int LW = WORD_W / MASK_W;

  // ----------------------------------------------------------------
  // One storage column per byte lane
  // ----------------------------------------------------------------
  for (genvar g = 0; g < MASK_W; g++) begin : g_lane
    logic [LW-1:0] col_r [0:(1<<ADDR_W)-1];

    always_ff @(posedge clock) begin
      if (port.we && port.wmask[g]) begin
        col_r[port.waddr] <= port.wdata[g*LW +: LW];
      end
    end

    always_ff @(posedge clock) begin
      port.rdata[g*LW +: LW] <= col_r[port.raddr];
    end
  end
endmodule

// ===== verif/qpdbs_properties.sv
/* Pin checks of the two-port burst memory.
   Assumes a bind into qpdbs_top and one system clock. */
`timescale 1ns/1ns
module qpdbs_properties #(
  parameter int DATA_W = 36
) (
  input wire logic              clock,
  input wire logic              sys_rst,
  input wire logic              link_clock_true,
  input wire logic              link_clock_complement,
  input wire logic              read_select_n,
  input wire logic [DATA_W-1:0] read_data_out,
  input wire logic              read_data_oe,
  input wire logic              read_data_valid,
  input wire logic              echo_clock_true,
  input wire logic              echo_clock_complement
);
  // ------------------------------
  // Helpers
  // ------------------------------
  logic [2:0] up_r;
  logic [5:0] rd_age_r;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) rd_age_r <= 6'h3f;
    else if ($rose(link_clock_true) && !read_select_n) rd_age_r <= 6'h0;
    else if (rd_age_r != 6'h3f) rd_age_r <= rd_age_r + 6'h1;
  end
  sequence s_start; $rose(read_data_valid); endsequence
  sequence s_beat2; $rose(echo_clock_true) && read_data_valid; endsequence
  property p_echo_t;
    up_r == 3'h7 && $rose(link_clock_true) |-> ##[1:5] $rose(echo_clock_true);
  endproperty
  property p_echo_c;
    up_r == 3'h7 && $rose(link_clock_complement) |-> ##[1:5] $rose(echo_clock_complement);
  endproperty
  property p_data_echo;
    !$stable(read_data_out) |-> $rose(echo_clock_true) || $rose(echo_clock_complement);
  endproperty
  property p_valid_edge; $changed(read_data_valid) |-> $rose(echo_clock_complement); endproperty
  property p_oe; read_data_oe == read_data_valid; endproperty
  property p_burst; s_start |-> read_data_valid [*8]; endproperty
  property p_beat2; s_start |-> ##[5:8] s_beat2; endproperty
  property p_cause; s_start |-> rd_age_r inside {[6'h3:6'h19]}; endproperty
  // ------------------------------
  // Assertions
  // ------------------------------
  a_echo_t: assert property (p_echo_t) else $error("true echo missing");
  a_echo_c: assert property (p_echo_c) else $error("complement echo missing");
  a_data_echo: assert property (p_data_echo) else $error("data moved off echo edge");
  a_valid_edge: assert property (p_valid_edge) else $error("valid moved off edge");
  a_oe: assert property (p_oe) else $error("enable differs from valid");
  a_burst: assert property (p_burst) else $error("burst too short");
  a_beat2: assert property (p_beat2) else $error("second beat late");
  a_cause: assert property (p_cause) else $error("read latency off");
endmodule

// ===== verif/qpdbs_ctl_model.sv
/* Controller model: makes the input clock pair and drives commands.
   Assumes the bench calls issue once per input clock cycle. */
`timescale 1ns/1ns
module qpdbs_ctl_model (
  input  wire logic        clock,
  output logic             link_clock_true,
  output logic             link_clock_complement,
  output logic             read_select_n,
  output logic             write_select_n,
  output logic [18:0]      shared_address,
  output logic [3:0]       byte_write_enable_n,
  output logic [35:0]      write_data_in
);
  logic [2:0] t_s = 3'h0;
  logic [2:0] c_s = 3'h0;
  initial begin
    {link_clock_true, link_clock_complement, read_select_n, write_select_n} = 4'h7;
    shared_address = 19'h0;
    byte_write_enable_n = 4'hf;
    write_data_in = 36'h0;
    #7;
    forever begin
      #62 {link_clock_true, link_clock_complement} = 2'h2;
      #63 {link_clock_true, link_clock_complement} = 2'h1;
    end
  end
  always @(posedge clock) begin
    t_s <= {t_s[1:0], link_clock_true};
    c_s <= {c_s[1:0], link_clock_complement};
  end
  task automatic wait_edge(input logic cmp);
    do @(posedge clock);
    while (cmp ? !(c_s[1] && !c_s[2]) : !(t_s[1] && !t_s[2]));
    @(posedge clock);
  endtask
  task automatic issue(input logic rd, input logic wr, input logic [18:0] ra,
                       input logic [18:0] wa, input logic [35:0] d1, input logic [35:0] d2,
                       input logic [3:0] b1, input logic [3:0] b2);
    wait_edge(1'b1);
    read_select_n       <= !rd;
    write_select_n      <= !wr;
    shared_address      <= ra;
    write_data_in       <= d1;
    byte_write_enable_n <= b1;
    wait_edge(1'b0);
    read_select_n       <= 1'b1;
    write_select_n      <= 1'b1;
    shared_address      <= wa;
    write_data_in       <= d2;
    byte_write_enable_n <= b2;
  endtask
endmodule

// ===== verif/tb_top.sv
/* Bench top: controller model, memory block and checker bind.
   Assumes a 100 MHz system clock and a 125 ns input clock pair. */
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic rd; logic wr; logic [18:0] ra; logic [18:0] wa;
    logic [35:0] d1; logic [35:0] d2; logic [3:0] b1; logic [3:0] b2;
  } qpdbs_row_t;
  logic        clock, sys_rst, dll_bypass_n, lk_t, lk_c, rd_n, wr_n;
  logic [18:0] addr;
  logic [3:0]  bwe_n;
  logic [35:0] wdata, read_data_out;
  logic        read_data_oe, read_data_valid, echo_clock_true, echo_clock_complement;
  logic        ec_p, et_p, vd_p;
  logic [71:0] ref_mem [logic [18:0]];
  logic [35:0] exp_q [$];
  int          miscompares, num_checks;
  time         t_cmd, t_first;
  qpdbs_row_t  rows [8] = '{
    '{1'b0, 1'b1, 19'h0, 19'h10, 36'h123456789, 36'h987654321, 4'h0, 4'h0},
    '{1'b0, 1'b1, 19'h0, 19'h7ffff, 36'hf0f0f0f0f, 36'h0f0f0f0f0, 4'h0, 4'h0},
    '{1'b1, 1'b1, 19'h10, 19'h20, 36'haaaaaaaaa, 36'h555555555, 4'h0, 4'h0},
    '{1'b1, 1'b1, 19'h7ffff, 19'h10, 36'h0, 36'hfffffffff, 4'ha, 4'h5},
    '{1'b1, 1'b1, 19'h10, 19'h10, 36'h333333333, 36'hccccccccc, 4'h3, 4'hc},
    '{1'b0, 1'b0, 19'h20, 19'h20, 36'h0, 36'h0, 4'h0, 4'h0},
    '{1'b1, 1'b0, 19'h20, 19'h0, 36'h0, 36'h0, 4'hf, 4'hf},
    '{1'b1, 1'b0, 19'h10, 19'h0, 36'h0, 36'h0, 4'hf, 4'hf}};
  qpdbs_ctl_model u_ctl (.clock(clock), .link_clock_true(lk_t), .link_clock_complement(lk_c),
    .read_select_n(rd_n), .write_select_n(wr_n), .shared_address(addr),
    .byte_write_enable_n(bwe_n), .write_data_in(wdata));
  qpdbs_top u_dut (.clock(clock), .sys_rst(sys_rst), .link_clock_true(lk_t),
    .link_clock_complement(lk_c), .read_select_n(rd_n), .write_select_n(wr_n),
    .dll_bypass_n(dll_bypass_n), .shared_address(addr), .byte_write_enable_n(bwe_n),
    .write_data_in(wdata), .read_data_out(read_data_out), .read_data_oe(read_data_oe),
    .read_data_valid(read_data_valid), .echo_clock_true(echo_clock_true),
    .echo_clock_complement(echo_clock_complement));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk36(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[ERR] %0t value %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic op(input qpdbs_row_t r);
    logic [71:0] w;
    logic [7:0]  m;
    logic [71:0] d;
    w = ref_mem.exists(r.wa) ? ref_mem[r.wa] : 72'h0;
    m = {r.b2, r.b1};
    d = {r.d2, r.d1};
    for (int i = 0; i < 8; i++) if (!m[i]) w[i*9 +: 9] = d[i*9 +: 9];
    if (r.wr) ref_mem[r.wa] = w;
    if (r.rd) begin
      exp_q.push_back(ref_mem[r.ra][35:0]);
      exp_q.push_back(ref_mem[r.ra][71:36]);
    end
    u_ctl.issue(r.rd, r.wr, r.ra, r.wa, r.d1, r.d2, r.b1, r.b2);
  endtask
  task automatic drain(input string name);
    repeat (40) @(posedge clock);
    chk_rng(exp_q.size(), 0, 0);
    $display("test %s done", name);
  endtask
  task automatic lat_test(input logic byp_n, input int lo, input int hi);
    @(posedge clock) dll_bypass_n <= byp_n;
    t_first = 0;
    op(rows[5]);
    op(rows[6]);
    drain("latency");
    chk_rng(int'(t_first - t_cmd), lo, hi);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge lk_t) if (!rd_n) t_cmd = $time;
  always @(negedge clock) begin
    if (read_data_valid && ((echo_clock_complement && !ec_p) || (echo_clock_true && !et_p))) begin
      if (!vd_p) t_first = $time;
      if (exp_q.size() == 0) chk_rng(1, 0, 0);
      else chk36(read_data_out, exp_q.pop_front());
    end
    {ec_p, et_p, vd_p} = {echo_clock_complement, echo_clock_true, read_data_valid};
  end
  initial begin
    sys_rst <= 1'b1;
    dll_bypass_n <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clock);
    foreach (rows[i]) op(rows[i]);
    drain("table");
    lat_test(1'b1, 190, 250);
    lat_test(1'b0, 65, 125);
    @(posedge clock) {sys_rst, dll_bypass_n} <= 2'h3;
    repeat (2) @(posedge clock);
    #1;
    chk36(read_data_out, 36'h0);
    chk36({32'h0, read_data_valid, read_data_oe, echo_clock_true, echo_clock_complement}, 36'h0);
    @(posedge clock) sys_rst <= 1'b0;
    repeat (5) @(posedge clock);
    op('{1'b1, 1'b0, 19'h7ffff, 19'h0, 36'h0, 36'h0, 4'hf, 4'hf});
    drain("reset");
    give_verdict();
  end
  // Several times the expected run of about 3.5 us
  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end
endmodule
bind qpdbs_top qpdbs_properties #(.DATA_W(DATA_W)) u_props (.clock(clock), .sys_rst(sys_rst),
  .link_clock_true(link_clock_true), .link_clock_complement(link_clock_complement),
  .read_select_n(read_select_n), .read_data_out(read_data_out), .read_data_oe(read_data_oe),
  .read_data_valid(read_data_valid), .echo_clock_true(echo_clock_true),
  .echo_clock_complement(echo_clock_complement));
